//--- common/php_pkg.sv
// constants shared by both ends of the printer parallel port.
// assumes one system clock on both ends.
package php_pkg;
	localparam int DATA_W = 8;
	localparam int NIB_W = 4;
	// acknowledge pulse length in ns; blink half period in clock cycles
	localparam int ACK_NS = 5000;
	localparam int CLK_NS = 25;
	localparam int ACK_CYC = (ACK_NS + CLK_NS - 1) / CLK_NS;
	localparam int BLINK_CYC = 4096;
	localparam int CNT_W = 13;
	localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	typedef enum logic {REV_NIBBLE, REV_BYTE} php_rev_t;
	typedef enum {FW_IDLE, FW_HOLD, FW_ACK} php_fwd_t;
endpackage : php_pkg

//--- common/php_if.sv
// parallel port wires between host and printer.
// assumes both ends share mclk; printer resynchronises host lines anyway.
`timescale 1ns/1ps
interface php_if;
	logic strobeN;
	logic [php_pkg::DATA_W-1:0] data;
	logic initN;
	logic selInN;
	logic revReq;
	logic revMode;
	logic ackN;
	logic busy;
	logic paperFaultOut;
	logic select;
	logic errorN;
	logic [php_pkg::DATA_W-1:0] revData;
	logic revValid;
	modport host (output strobeN, data, initN, selInN, revReq, revMode,
		input ackN, busy, paperFaultOut, select, errorN, revData, revValid);
	modport printer (input strobeN, data, initN, selInN, revReq, revMode,
		output ackN, busy, paperFaultOut, select, errorN, revData, revValid);
endinterface : php_if

//--- core/php_printer_end.sv
// printer end: parallel byte receiver, online decision and error handling.
// assumes host lines are asynchronous; serial bytes arrive from a uart on mclk.
`timescale 1ns/1ps
// Summary of operation
// - any error halts print, feed, cut
// - error lamp blinks while error active
// - drop serial bytes with parity/framing/overrun
// - accept full byte on eight lines
// - capture data after host strobe edge once buffer has room
// - ack pulse and busy level pace host
// - busy from strobe until its ack
// - pulse ack for each accepted parallel byte
// - reverse channel nibble or byte mode
// - offline after power-up or init until ready
// - offline in self-test, cover open, manual feed
// - offline on paper end or enabled near-end
// - offline on supply fault, macro wait, error
// - paper fault line reports paper problems
// - init abandons current job
// - select-in level sets online or offline
// - select output shows printer selected
module php_printer_end (
	input wire logic mclk,
	input wire logic sys_rst,
	php_if.printer port,
	input wire logic errorPresent,
	input wire logic selfTest,
	input wire logic coverOpen,
	input wire logic manualFeed,
	input wire logic rollEnd,
	input wire logic nearEnd,
	input wire logic paperShortageHaltCommand,
	input wire logic supplyFault,
	input wire logic macroStandby,
	input wire logic engineReady,
	input wire logic [php_pkg::DATA_W-1:0] serData,
	input wire logic serValid,
	input wire logic serParityErr,
	input wire logic serFramingErr,
	input wire logic serOverrunErr,
	input wire logic [php_pkg::DATA_W-1:0] revByte,
	input wire logic revByteValid,
	output logic revByteReady,
	output logic [php_pkg::DATA_W-1:0] rxData,
	output logic rxValid,
	input wire logic rxReady,
	output logic rxFromSerial,
	output logic haltEngine,
	output logic abortJob,
	output logic errorLamp,
	output logic online
);
	// ==========================================================
	// synchronisers
	logic [1:0] strobeSync_q, initSync_q, selSync_q, revSync_q, modeSync_q;
	logic [php_pkg::DATA_W-1:0] dataSync1_q, dataSync2_q;
	logic strobePrev_q;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			strobeSync_q <= 2'h3;
			initSync_q <= 2'h3;
			selSync_q <= 2'h3;
			revSync_q <= 2'h0;
			modeSync_q <= 2'h0;
			dataSync1_q <= php_pkg::BYTE_ZERO;
			dataSync2_q <= php_pkg::BYTE_ZERO;
			strobePrev_q <= 1'b1;
		end else begin
			strobeSync_q <= {strobeSync_q[0], port.strobeN};
			initSync_q <= {initSync_q[0], port.initN};
			selSync_q <= {selSync_q[0], port.selInN};
			revSync_q <= {revSync_q[0], port.revReq};
			modeSync_q <= {modeSync_q[0], port.revMode};
			dataSync1_q <= port.data;
			dataSync2_q <= dataSync1_q;
			strobePrev_q <= strobeSync_q[1];
		end
	end
	logic strobeFall, initActive, selectedIn;
	assign strobeFall = strobePrev_q & ~strobeSync_q[1];
	assign initActive = ~initSync_q[1];
	assign selectedIn = ~selSync_q[1];

	// ==========================================================
	// online decision
	logic ready_q, online_d;
	// ready only after engine reports it
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			ready_q <= 1'b0;
		else if (initActive)
			ready_q <= 1'b0;
		else if (engineReady)
			ready_q <= 1'b1;
	end
	logic paperHalt;
	assign paperHalt = rollEnd | (nearEnd & paperShortageHaltCommand);
	always_comb begin
		online_d = ready_q & selectedIn & ~initActive & ~selfTest & ~coverOpen & ~manualFeed
			& ~paperHalt & ~supplyFault & ~macroStandby & ~errorPresent;
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			online <= 1'b0;
		else
			online <= online_d;
	end
	assign haltEngine = errorPresent;
	assign abortJob = initActive;

	// ==========================================================
	// two-entry receive buffer, fed by parallel or serial source
	logic [php_pkg::DATA_W:0] buf_q [2];
	logic [1:0] count_q;
	logic wrPtr_q, rdPtr_q;
	logic inValid, inReady, fromPar;
	logic [php_pkg::DATA_W-1:0] inData;
	php_pkg::php_fwd_t fwd_q;
	logic [php_pkg::CNT_W-1:0] ackCnt_q;
	logic serOk;
	assign serOk = serValid & ~(serParityErr | serFramingErr | serOverrunErr);
	assign fromPar = (fwd_q == php_pkg::FW_HOLD);
	assign inValid = fromPar | serOk;
	assign inData = fromPar ? dataSync2_q : serData;
	assign inReady = (count_q != 2'h2);
	assign rxValid = (count_q != 2'h0);
	assign rxData = buf_q[rdPtr_q][php_pkg::DATA_W-1:0];
	assign rxFromSerial = buf_q[rdPtr_q][php_pkg::DATA_W];
	// parallel wins; a serial byte in the same cycle is lost, acceptable since one build has one port
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			count_q <= 2'h0;
			wrPtr_q <= 1'b0;
			rdPtr_q <= 1'b0;
		end else if (initActive) begin
			count_q <= 2'h0;
			wrPtr_q <= 1'b0;
			rdPtr_q <= 1'b0;
		end else begin
			count_q <= count_q + {1'b0, inValid & inReady} - {1'b0, rxValid & rxReady};
			if (inValid & inReady)
				wrPtr_q <= ~wrPtr_q;
			if (rxValid & rxReady)
				rdPtr_q <= ~rdPtr_q;
		end
	end
	always_ff @(posedge mclk) begin
		if (inValid & inReady)
			buf_q[wrPtr_q] <= {~fromPar, inData};
	end

	// ==========================================================
	// forward handshake
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			fwd_q <= php_pkg::FW_IDLE;
			ackCnt_q <= php_pkg::CNT_ZERO;
		end else if (initActive) begin
			fwd_q <= php_pkg::FW_IDLE;
			ackCnt_q <= php_pkg::CNT_ZERO;
		end else begin
			unique case (fwd_q)
				php_pkg::FW_IDLE: begin
					if (strobeFall & online)
						fwd_q <= php_pkg::FW_HOLD;
				end
				php_pkg::FW_HOLD: begin
					if (inReady) begin
						fwd_q <= php_pkg::FW_ACK;
						ackCnt_q <= php_pkg::CNT_W'(php_pkg::ACK_CYC);
					end
				end
				php_pkg::FW_ACK: begin
					ackCnt_q <= ackCnt_q - php_pkg::CNT_ONE;
					if (ackCnt_q == php_pkg::CNT_ONE)
						fwd_q <= php_pkg::FW_IDLE;
				end
			endcase
		end
	end
	assign port.ackN = ~(fwd_q == php_pkg::FW_ACK);
	assign port.busy = (fwd_q != php_pkg::FW_IDLE) | ~online;

	// ==========================================================
	// status lines and lamp
	logic [php_pkg::CNT_W-1:0] blinkCnt_q;
	logic blink_q;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			blinkCnt_q <= php_pkg::CNT_ZERO;
			blink_q <= 1'b0;
		end else if (!errorPresent) begin
			blinkCnt_q <= php_pkg::CNT_ZERO;
			blink_q <= 1'b0;
		end else if (blinkCnt_q == php_pkg::CNT_W'(php_pkg::BLINK_CYC - 1)) begin
			blinkCnt_q <= php_pkg::CNT_ZERO;
			blink_q <= ~blink_q;
		end else begin
			blinkCnt_q <= blinkCnt_q + php_pkg::CNT_ONE;
		end
	end
	assign errorLamp = errorPresent & ~blink_q;
	assign port.paperFaultOut = rollEnd | nearEnd;
	assign port.select = online;
	assign port.errorN = ~errorPresent;

	// ==========================================================
	// reverse channel
	logic [php_pkg::DATA_W-1:0] revOut_q;
	logic revValid_q;
	assign revByteReady = revSync_q[1] & ~revValid_q;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			revOut_q <= php_pkg::BYTE_ZERO;
			revValid_q <= 1'b0;
		end else if (!revSync_q[1]) begin
			revValid_q <= 1'b0;
		end else if (revByteValid & ~revValid_q) begin
			// nibble mode sends only the low nibble, high bits zero; byte mode whole byte
			revOut_q <= (modeSync_q[1] == php_pkg::REV_BYTE) ? revByte
				: {{php_pkg::NIB_W{1'b0}}, revByte[php_pkg::NIB_W-1:0]};
			revValid_q <= 1'b1;
		end
	end
	assign port.revData = revOut_q;
	assign port.revValid = revValid_q;
endmodule : php_printer_end

//--- core/php_host_end.sv
// host end: sends bytes with strobe, paced by busy and ack.
// assumes printer runs on the same mclk; busy, ack, select and paper fault are still synchronised, reverse data passes straight through.
`timescale 1ns/1ps
module php_host_end (
	input wire logic mclk,
	input wire logic sys_rst,
	php_if.host port,
	input wire logic [php_pkg::DATA_W-1:0] txData,
	input wire logic txValid,
	output logic txReady,
	input wire logic initReq,
	input wire logic selectOn,
	input wire logic revRequest,
	input wire logic revByteMode,
	output logic [php_pkg::DATA_W-1:0] revData,
	output logic revValid,
	output logic printerSelected,
	output logic paperFault
);
	logic [1:0] busySync_q, ackSync_q, selSync_q, peSync_q;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			busySync_q <= 2'h3;
			ackSync_q <= 2'h3;
			selSync_q <= 2'h0;
			peSync_q <= 2'h0;
		end else begin
			busySync_q <= {busySync_q[0], port.busy};
			ackSync_q <= {ackSync_q[0], port.ackN};
			selSync_q <= {selSync_q[0], port.select};
			peSync_q <= {peSync_q[0], port.paperFaultOut};
		end
	end
	// strobe low while data held; send only when not busy
	logic strobe_q, wait_q;
	logic [php_pkg::DATA_W-1:0] data_q;
	assign txReady = ~busySync_q[1] & ~strobe_q & ~wait_q & ~initReq;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			strobe_q <= 1'b0;
			wait_q <= 1'b0;
			data_q <= php_pkg::BYTE_ZERO;
		end else if (txValid & txReady) begin
			data_q <= txData;
			strobe_q <= 1'b1;
		end else if (strobe_q & busySync_q[1]) begin
			strobe_q <= 1'b0;
			wait_q <= 1'b1;
		end else if (wait_q & ~busySync_q[1] & ackSync_q[1]) begin
			wait_q <= 1'b0;
		end
	end
	assign port.strobeN = ~strobe_q;
	assign port.data = data_q;
	// init line; select-in level; reverse mode choice
	assign port.initN = ~initReq;
	assign port.selInN = ~selectOn;
	assign port.revReq = revRequest;
	assign port.revMode = revByteMode;
	assign revData = port.revData;
	assign revValid = port.revValid;
	assign printerSelected = selSync_q[1];
	assign paperFault = peSync_q[1];
endmodule : php_host_end

//--- bench/php_asserts.sv
// checker on the parallel port wires between host and printer ends.
// assumes it is instantiated beside the interface, sharing mclk and sys_rst.
`timescale 1ns/1ps
module php_asserts (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic strobeN,
	input wire logic [php_pkg::DATA_W-1:0] data,
	input wire logic initN,
	input wire logic selInN,
	input wire logic revMode,
	input wire logic ackN,
	input wire logic busy,
	input wire logic select,
	input wire logic [php_pkg::DATA_W-1:0] revData,
	input wire logic revValid
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic [php_pkg::CNT_W-1:0] ackLen_q;
	// =========================
	// ack pulse length counter
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) ackLen_q <= php_pkg::CNT_ZERO;
		else if (!ackN) ackLen_q <= ackLen_q + php_pkg::CNT_ONE;
		else ackLen_q <= php_pkg::CNT_ZERO;
	end
	// =========================
	// assertions
	chk_ack_pulse_len: assert property ($rose(ackN) |-> ackLen_q == php_pkg::ACK_CYC)
		else $error("ack pulse length wrong");
	chk_busy_over_ack: assert property (!ackN |-> busy)
		else $error("busy low during ack");
	chk_strobe_gets_busy: assert property ($fell(strobeN) |-> ##[1:8] busy)
		else $error("no busy after strobe");
	chk_host_waits_busy: assert property ($fell(strobeN) |-> !$past(busy))
		else $error("strobe while busy");
	chk_data_held: assert property (!strobeN && !$past(strobeN) |-> $stable(data))
		else $error("data moved under strobe");
	chk_selin_offline: assert property (selInN [*6] |-> !select)
		else $error("online with select-in high");
	chk_init_offline: assert property (!initN [*6] |-> !select)
		else $error("online during init");
	chk_offline_busy: assert property (!select |-> busy)
		else $error("not busy while offline");
	chk_nibble_high_zero: assert property (revValid && !revMode && !$past(revMode, 4) |-> revData[7:4] == 4'h0)
		else $error("nibble mode high bits set");
	cover property ($fell(ackN));
	cover property ($rose(select));
	cover property ($rose(revValid));
endmodule : php_asserts

//--- bench/printer_host_port_status_tb_top.sv
// bench joining host end and printer end through the port interface.
// assumes one 40 MHz clock; inputs move 2 ns after each rising edge.
`timescale 1ns/1ps
module printer_host_port_status_tb_top;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [6:0] offC = 7'h00;
	logic nearEnd = 1'b0, haltCmd = 1'b0, engineReady = 1'b0, serValid = 1'b0, revByteValid = 1'b0;
	logic [2:0] serErr = 3'h0;
	logic [7:0] serData = 8'h00, revByte = 8'h00, txData = 8'h00;
	logic rxReady = 1'b0, txValid = 1'b0, initReq = 1'b0, selectOn = 1'b0, revRequest = 1'b0, revByteMode = 1'b0;
	logic revByteReady, rxValid, rxFromSerial, haltEngine, abortJob, errorLamp, online, txReady;
	logic hRevValid, printerSelected, paperFault, lamp0;
	logic [7:0] rxData, hRevData;
	int num_errors = 0, samples_checked = 0;
	php_if pif ();
	wire [4:0] ev = {hRevValid, revByteReady, txReady, rxValid, online};
	php_printer_end php_printer_end_i (.mclk(mclk), .sys_rst(sys_rst), .port(pif.printer), .errorPresent(offC[6]),
		.selfTest(offC[0]), .coverOpen(offC[1]), .manualFeed(offC[2]), .rollEnd(offC[3]), .nearEnd(nearEnd),
		.paperShortageHaltCommand(haltCmd), .supplyFault(offC[4]), .macroStandby(offC[5]),
		.engineReady(engineReady), .serData(serData), .serValid(serValid), .serParityErr(serErr[0]),
		.serFramingErr(serErr[1]), .serOverrunErr(serErr[2]), .revByte(revByte), .revByteValid(revByteValid),
		.revByteReady(revByteReady), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
		.rxFromSerial(rxFromSerial), .haltEngine(haltEngine), .abortJob(abortJob), .errorLamp(errorLamp),
		.online(online));
	php_host_end php_host_end_i (.mclk(mclk), .sys_rst(sys_rst), .port(pif.host), .txData(txData),
		.txValid(txValid), .txReady(txReady), .initReq(initReq), .selectOn(selectOn), .revRequest(revRequest),
		.revByteMode(revByteMode), .revData(hRevData), .revValid(hRevValid), .printerSelected(printerSelected),
		.paperFault(paperFault));
	php_asserts php_asserts_i (.mclk(mclk), .sys_rst(sys_rst), .strobeN(pif.strobeN), .data(pif.data),
		.initN(pif.initN), .selInN(pif.selInN), .revMode(pif.revMode), .ackN(pif.ackN), .busy(pif.busy),
		.select(pif.select), .revData(pif.revData), .revValid(pif.revValid));
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	// =========================
	// shared tasks
	task automatic tick(input int n);
		repeat (n) @(posedge mclk) #2;
	endtask : tick
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// bounded wait; running out ends the run as a mismatch
	task automatic waitEv(input int k, input logic v, input int lim);
		int i;
		for (i = 0; i < lim && ev[k] !== v; i++) tick(1);
		if (ev[k] !== v) begin
			num_errors++;
			$display("BAD wait on event %0d", k);
			end_sim();
		end
	endtask : waitEv
	task automatic send(input logic [7:0] b);
		waitEv(2, 1'b1, 600);
		txData = b;
		txValid = 1'b1;
		tick(1);
		txValid = 1'b0;
	endtask : send
	task automatic recv(input logic [7:0] exp, input logic ser);
		waitEv(1, 1'b1, 600);
		chk("rxData", rxData, exp);
		chk("rxFromSerial", rxFromSerial, ser);
		rxReady = 1'b1;
		tick(1);
		rxReady = 1'b0;
		// one idle edge so back-to-back calls never re-raise ready in the same step
		tick(1);
	endtask : recv
	// =========================
	// scenarios
	initial begin
		tick(4);
		sys_rst = 1'b0;
		tick(6);
		chk("online before ready", online, 1'b0);
		engineReady = 1'b1;
		selectOn = 1'b1;
		waitEv(0, 1'b1, 50);
		tick(4);
		chk("select", pif.select, 1'b1);
		chk("printerSelected", printerSelected, 1'b1);
		send(8'hA5);
		recv(8'hA5, 1'b0);
		// receiver stalls: two fit, third must hold busy
		send(8'h11);
		send(8'h22);
		send(8'h33);
		tick(300);
		chk("busy on full buffer", pif.busy, 1'b1);
		recv(8'h11, 1'b0);
		recv(8'h22, 1'b0);
		recv(8'h33, 1'b0);
		for (int k = 0; k < 3; k++) begin
			serData = 8'h5A;
			serErr = 3'h1 << k;
			serValid = 1'b1;
			tick(1);
			serValid = 1'b0;
			serErr = 3'h0;
			tick(5);
			chk("rxValid bad serial", rxValid, 1'b0);
		end
		serValid = 1'b1;
		tick(1);
		serValid = 1'b0;
		recv(8'h5A, 1'b1);
		for (int k = 0; k < 7; k++) begin
			offC = 7'h01 << k;
			tick(6);
			chk("online offline cause", online, 1'b0);
			chk("busy offline", pif.busy, 1'b1);
			if (k == 6) begin
				chk("haltEngine", haltEngine, 1'b1);
				chk("errorN", pif.errorN, 1'b0);
				chk("errorLamp on", errorLamp, 1'b1);
				lamp0 = errorLamp;
				tick(php_pkg::BLINK_CYC);
				chk("errorLamp blink", errorLamp, {7'h00, ~lamp0});
			end
			if (k >= 4) chk("online fault", online, 1'b0);
			if (k == 3) chk("paperFaultOut", pif.paperFaultOut, 1'b1);
			offC = 7'h00;
			waitEv(0, 1'b1, 50);
		end
		nearEnd = 1'b1;
		tick(6);
		chk("online near end", online, 1'b1);
		chk("paperFault host", paperFault, 1'b1);
		haltCmd = 1'b1;
		tick(6);
		chk("online near end halt", online, 1'b0);
		nearEnd = 1'b0;
		haltCmd = 1'b0;
		waitEv(0, 1'b1, 50);
		for (int k = 0; k < 2; k++) begin
			revByte = 8'h3C;
			revByteMode = k[0];
			revRequest = 1'b1;
			revByteValid = 1'b1;
			waitEv(3, 1'b1, 50);
			tick(1);
			revByteValid = 1'b0;
			waitEv(4, 1'b1, 50);
			chk("revData", hRevData, k ? 8'h3C : 8'h0C);
			revRequest = 1'b0;
			tick(8);
		end
		initReq = 1'b1;
		tick(6);
		chk("abortJob", abortJob, 1'b1);
		chk("online in init", online, 1'b0);
		initReq = 1'b0;
		waitEv(0, 1'b1, 50);
		selectOn = 1'b0;
		tick(8);
		chk("online select-in off", online, 1'b0);
		end_sim();
	end
endmodule : printer_host_port_status_tb_top
